// file: hdl/uec_pkg.sv
// shared constants, types and helpers of the up/down event counter bank
// assumes a 32-bit avalon-mm slave port with byte addresses
package uec_pkg;

    // ****************************************************************
    // geometry and limits
    // ****************************************************************
    localparam int UEC_NCH = 8;
    localparam logic [31:0] UEC_MAX_POS = 32'h7FFFFFFF;
    localparam logic [31:0] UEC_MAX_NEG = 32'h80000000;
    localparam logic [31:0] UEC_ZERO = 32'h00000000;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [8:0] UEC_OFF_ENABLE = 9'h000;
    localparam logic [8:0] UEC_OFF_IRQ_STAT = 9'h004;
    localparam logic [8:0] UEC_OFF_IRQ_MASK = 9'h008;
    localparam logic [8:0] UEC_OFF_FLAGS = 9'h00C;
    localparam logic [8:0] UEC_OFF_NV_CTRL = 9'h010;
    localparam logic [8:0] UEC_OFF_CH_BASE = 9'h040;
    localparam logic [8:0] UEC_OFF_CH_END = 9'h140;
    // word index inside one 32-byte channel window
    localparam logic [2:0] UEC_W_PRESET = 3'h0;
    localparam logic [2:0] UEC_W_COMPARE = 3'h1;
    localparam logic [2:0] UEC_W_COUNT = 3'h2;
    localparam logic [2:0] UEC_W_CAPT = 3'h3;
    localparam logic [2:0] UEC_W_TS_LO = 3'h4;
    localparam logic [2:0] UEC_W_TS_HI = 3'h5;
    // field positions
    localparam int UEC_NV_RESTORE_BIT = 0;
    localparam int UEC_IRQ_CAPT_LSB = 0;
    localparam int UEC_IRQ_WRAP_LSB = 8;

    // reset values
    localparam logic [7:0] UEC_RST_ENABLE = 8'h00;
    localparam logic [15:0] UEC_RST_IRQ = 16'h0000;
    localparam logic [31:0] UEC_RST_WORD = 32'h00000000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic up;
        logic dn;
        logic blk;
        logic psel;
        logic rst;
        logic frz_rst;
        logic frz_cnt;
    } uec_in_t;

    typedef struct packed {
        logic above;
        logic equal;
        logic below;
    } uec_flags_t;

    // signed three-way comparison of count against the compare value
    function automatic uec_flags_t uec_cmp(input logic [31:0] cnt,
                                           input logic [31:0] ref_v);
        uec_flags_t f;
        f.above = ($signed(cnt) > $signed(ref_v));
        f.equal = (cnt == ref_v);
        f.below = ($signed(cnt) < $signed(ref_v));
        return f;
    endfunction : uec_cmp

    // byte-enable merge of a write into a held word
    function automatic logic [31:0] uec_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        return r;
    endfunction : uec_be

endpackage : uec_pkg

// file: hdl/uec_chan.sv
// one up/down event counter with preset, compare flags and capture
// assumes inputs sampled only when pass_tick is high
`timescale 1ns/1ps

module uec_chan
    import uec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic pass_tick,
    input wire logic enable,
    input wire uec_in_t ins,
    input wire logic [31:0] preset,
    input wire logic [31:0] compare,
    input wire logic [63:0] date_time,
    input wire logic restore,
    input wire logic [31:0] restore_count,
    input wire logic [31:0] restore_capt,
    output logic [31:0] count_r,
    output logic [31:0] capt_r,
    output logic [63:0] capt_ts_r,
    output uec_flags_t flags_r,
    output logic capt_ev_r,
    output logic wrap_ev_r
);

    // ****************************************************************
    // edge detection against last pass
    // ****************************************************************
    uec_in_t prev_r;
    logic en_prev_r;
    uec_in_t rise;
    logic run, en_rise, load_base, up_ev, dn_ev, capture, wrap;
    logic [31:0] base, count_nxt;

    // rising edges only; levels and falls never move the count
    assign rise = uec_in_t'(ins & ~prev_r);
    assign run = pass_tick & enable;
    assign en_rise = run & ~en_prev_r;
    assign base = ins.psel ? preset : UEC_ZERO;
    assign load_base = en_rise | rise.rst | rise.frz_rst;
    assign up_ev = rise.up & ~rise.dn & ~ins.blk;
    assign dn_ev = rise.dn & ~rise.up & ~ins.blk;
    assign capture = run & (rise.frz_rst | rise.frz_cnt);
    // plain 32-bit arithmetic rolls over at both limits
    assign wrap = run & ~load_base & ~rise.psel &
        ((up_ev & (count_r == UEC_MAX_POS)) |
         (dn_ev & (count_r == UEC_MAX_NEG)));

    // loads outrank counting edges of the same pass
    assign count_nxt =
        restore ? restore_count :
        !run ? count_r :
        load_base ? base :
        rise.psel ? preset :
        up_ev ? count_r + 32'h00000001 :
        dn_ev ? count_r - 32'h00000001 :
        count_r;

    // ****************************************************************
    // state
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_r <= '0;
            en_prev_r <= 1'b0;
            count_r <= UEC_RST_WORD;
            capt_r <= UEC_RST_WORD;
            capt_ts_r <= {UEC_RST_WORD, UEC_RST_WORD};
            flags_r <= '0;
            capt_ev_r <= 1'b0;
            wrap_ev_r <= 1'b0;
        end
        else
        begin
            if (pass_tick)
            begin
                prev_r <= ins;
                en_prev_r <= enable;
            end
            count_r <= count_nxt;
            if (restore)
                capt_r <= restore_capt;
            else if (capture)
            begin
                capt_r <= count_r;
                capt_ts_r <= date_time;
            end
            // blocked or disabled counters show no flag
            flags_r <= (enable & ~prev_r.blk) ?
                uec_cmp(count_r, compare) : '0;
            capt_ev_r <= capture;
            wrap_ev_r <= wrap;
        end
    end

endmodule : uec_chan

// file: hdl/uec_top.sv
// bank of eight signed up/down event counters behind an avalon-mm slave
// assumes counter inputs synchronous to sys_clk, pass_tick one cycle wide
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

// Behaviour
// - eight independent counters, each with own state
// - count only on low-to-high input edges
// - increment at maximum wraps to most negative
// - decrement at most negative wraps to maximum
// - exclusive above, equal, below compare flags
// - block suspends counting and clears all flags
// - on enable load preset or zero
// - preset-select rise loads preset while running
// - reset commands load preset or zero
// - freeze-reset captures count, time, then resets
// - freeze-count captures count, time, keeps counting
// - save count and capture on power loss
module uec_top
    import uec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire uec_in_t [UEC_NCH-1:0] chan_in,
    input wire logic pass_tick,
    input wire logic [63:0] date_time,
    input wire logic power_fail_in,
    output logic [UEC_NCH-1:0] above_compare_flag,
    output logic [UEC_NCH-1:0] equal_compare_flag,
    output logic [UEC_NCH-1:0] below_compare_flag,
    output logic irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic wait_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic [7:0] enable_r;
    logic [15:0] stat_r;
    logic [15:0] mask_r;
    logic restore_r;
    logic [31:0] preset_r [UEC_NCH];
    logic [31:0] compare_r [UEC_NCH];
    logic [31:0] count_w [UEC_NCH];
    logic [31:0] capt_w [UEC_NCH];
    logic [63:0] ts_w [UEC_NCH];
    uec_flags_t flags_w [UEC_NCH];
    logic [UEC_NCH-1:0] capt_ev, wrap_ev;
    // non-volatile image: deliberately not reset
    logic [31:0] nv_count_m [UEC_NCH];
    logic [31:0] nv_capt_m [UEC_NCH];

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic req, take_wr, take_rd, in_chan;
    logic [8:0] ch_off;
    logic [2:0] ch_sel, ch_word;
    logic [31:0] ch_rd, glb_rd, rd_nxt;
    logic [15:0] stat_set, stat_clr, stat_nxt;
    logic [23:0] flag_vec;
    logic [31:0] be_clr, be_enable, be_mask;

    // one wait cycle per access: seen with wait high, answered next
    assign req = avs_read | avs_write;
    assign take_wr = avs_write & ~wait_r;
    assign take_rd = avs_read & wait_r;
    assign in_chan = (avs_address >= UEC_OFF_CH_BASE) &&
                     (avs_address < UEC_OFF_CH_END);
    assign ch_off = avs_address - UEC_OFF_CH_BASE;
    assign ch_sel = ch_off[7:5];
    assign ch_word = ch_off[4:2];

    // channel window read mux; unused words read as zero
    assign ch_rd =
        (ch_word == UEC_W_PRESET) ? preset_r[ch_sel] :
        (ch_word == UEC_W_COMPARE) ? compare_r[ch_sel] :
        (ch_word == UEC_W_COUNT) ? count_w[ch_sel] :
        (ch_word == UEC_W_CAPT) ? capt_w[ch_sel] :
        (ch_word == UEC_W_TS_LO) ? ts_w[ch_sel][31:0] :
        (ch_word == UEC_W_TS_HI) ? ts_w[ch_sel][63:32] :
        UEC_RST_WORD;

    // global register read mux; unmapped addresses read as zero
    assign flag_vec = {below_compare_flag, equal_compare_flag,
                       above_compare_flag};
    assign glb_rd =
        (avs_address == UEC_OFF_ENABLE) ? {24'h000000, enable_r} :
        (avs_address == UEC_OFF_IRQ_STAT) ? {16'h0000, stat_r} :
        (avs_address == UEC_OFF_IRQ_MASK) ? {16'h0000, mask_r} :
        (avs_address == UEC_OFF_FLAGS) ? {8'h00, flag_vec} :
        UEC_RST_WORD;
    assign rd_nxt = in_chan ? ch_rd : glb_rd;

    // ****************************************************************
    // interrupt status
    // ****************************************************************
    // byte-lane merges of the writable global words
    assign be_clr = uec_be(UEC_RST_WORD, avs_writedata, avs_byteenable);
    assign be_enable = uec_be({24'h000000, enable_r}, avs_writedata,
                              avs_byteenable);
    assign be_mask = uec_be({16'h0000, mask_r}, avs_writedata,
                            avs_byteenable);
    // a new event in the clearing cycle survives: set wins over clear
    assign stat_set = {wrap_ev, capt_ev};
    assign stat_clr = (take_wr && avs_address == UEC_OFF_IRQ_STAT) ?
        be_clr[15:0] :
        16'h0000;
    assign stat_nxt = (stat_r & ~stat_clr) | stat_set;

    // ****************************************************************
    // bus handshake and global registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wait_r <= 1'b1;
            rdata_r <= UEC_RST_WORD;
            irq_r <= 1'b0;
            enable_r <= UEC_RST_ENABLE;
            stat_r <= UEC_RST_IRQ;
            mask_r <= UEC_RST_IRQ;
            restore_r <= 1'b0;
        end
        else
        begin
            wait_r <= ~(req & wait_r);
            if (take_rd)
                rdata_r <= rd_nxt;
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & mask_r);
            if (take_wr && avs_address == UEC_OFF_ENABLE)
                enable_r <= be_enable[7:0];
            if (take_wr && avs_address == UEC_OFF_IRQ_MASK)
                mask_r <= be_mask[15:0];
            restore_r <= take_wr && avs_address == UEC_OFF_NV_CTRL &&
                avs_byteenable[0] && avs_writedata[UEC_NV_RESTORE_BIT];
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign irq = irq_r;

    // ****************************************************************
    // counter channels
    // ****************************************************************
    for (genvar g = 0; g < UEC_NCH; g++)
    begin : g_ch
        logic wr_pre, wr_cmp;

        // per-channel setting writes
        assign wr_pre = take_wr && in_chan && ch_sel == 3'(g) &&
                        ch_word == UEC_W_PRESET;
        assign wr_cmp = take_wr && in_chan && ch_sel == 3'(g) &&
                        ch_word == UEC_W_COMPARE;

        always_ff @(posedge sys_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                preset_r[g] <= UEC_RST_WORD;
                compare_r[g] <= UEC_RST_WORD;
            end
            else
            begin
                if (wr_pre)
                    preset_r[g] <= uec_be(preset_r[g], avs_writedata,
                                          avs_byteenable);
                if (wr_cmp)
                    compare_r[g] <= uec_be(compare_r[g], avs_writedata,
                                           avs_byteenable);
            end
        end

        // each instance keeps its own state and settings
        uec_chan u_chan (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .pass_tick(pass_tick),
            .enable(enable_r[g]),
            .ins(chan_in[g]),
            .preset(preset_r[g]),
            .compare(compare_r[g]),
            .date_time(date_time),
            .restore(restore_r),
            .restore_count(nv_count_m[g]),
            .restore_capt(nv_capt_m[g]),
            .count_r(count_w[g]),
            .capt_r(capt_w[g]),
            .capt_ts_r(ts_w[g]),
            .flags_r(flags_w[g]),
            .capt_ev_r(capt_ev[g]),
            .wrap_ev_r(wrap_ev[g])
        );

        assign above_compare_flag[g] = flags_w[g].above;
        assign equal_compare_flag[g] = flags_w[g].equal;
        assign below_compare_flag[g] = flags_w[g].below;

        // keeps refreshing while the supply warning stands
        always_ff @(posedge sys_clk)
        begin
            if (power_fail_in)
            begin
                nv_count_m[g] <= count_w[g];
                nv_capt_m[g] <= capt_w[g];
            end
        end

        // ************************************************************
        // checks
        // ************************************************************
        uec_in_t smp_r;
        uec_in_t rs;
        logic en_q_r;
        logic quiet;

        // helper copy of the last-pass samples
        always_ff @(posedge sys_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                smp_r <= '0;
                en_q_r <= 1'b0;
            end
            else if (pass_tick)
            begin
                smp_r <= chan_in[g];
                en_q_r <= enable_r[g];
            end
        end

        // quiet: a pass with no load, block or restore, plain counting
        assign rs = uec_in_t'(chan_in[g] & ~smp_r);
        assign quiet = pass_tick && enable_r[g] && en_q_r && !restore_r &&
                       !rs.rst && !rs.frz_rst && !rs.psel &&
                       !chan_in[g].blk;

        a_count_step: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            quiet && rs.up && !rs.dn && count_w[g] != UEC_MAX_POS
            |=> count_w[g] == $past(count_w[g]) + 32'h00000001)
            else $error("up edge did not add one");

        a_up_wrap: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            quiet && rs.up && !rs.dn && count_w[g] == UEC_MAX_POS
            |=> count_w[g] == UEC_MAX_NEG && wrap_ev[g])
            else $error("up wrap wrong");

        a_down_wrap: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            quiet && rs.dn && !rs.up && count_w[g] == UEC_MAX_NEG
            |=> count_w[g] == UEC_MAX_POS && wrap_ev[g])
            else $error("down wrap wrong");

        a_flag_onehot: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            enable_r[g] && !smp_r.blk && $stable(enable_r[g]) &&
            $stable(smp_r)
            |=> $onehot(flags_w[g]) &&
                flags_w[g] == uec_cmp($past(count_w[g]),
                                      $past(compare_r[g])))
            else $error("compare flags wrong");

        a_block_flags: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            smp_r.blk |=> flags_w[g] == '0)
            else $error("flags active while blocked");

        a_no_tick_hold: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            !pass_tick && !restore_r |=> $stable(count_w[g]))
            else $error("count moved between passes");

        a_enable_load: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            pass_tick && enable_r[g] && !en_q_r && !restore_r
            |=> count_w[g] == ($past(chan_in[g].psel) ?
                               $past(preset_r[g]) : UEC_ZERO))
            else $error("enable load wrong");

        a_reset_prio: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            pass_tick && enable_r[g] && en_q_r && !restore_r && rs.rst
            |=> count_w[g] == ($past(chan_in[g].psel) ?
                               $past(preset_r[g]) : UEC_ZERO))
            else $error("reset load wrong");

        a_freeze_reset: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            pass_tick && enable_r[g] && !restore_r && rs.frz_rst
            |=> capt_w[g] == $past(count_w[g]) &&
                ts_w[g] == $past(date_time) ##1 stat_r[g])
            else $error("freeze-reset capture wrong");

        a_preset_rise: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            pass_tick && enable_r[g] && en_q_r && !restore_r &&
            !rs.rst && !rs.frz_rst && rs.psel
            |=> count_w[g] == $past(preset_r[g]))
            else $error("preset edge load wrong");

        a_freeze_count: assert property (
            @(posedge sys_clk) disable iff (!resetn)
            pass_tick && enable_r[g] && !restore_r && rs.frz_cnt
            |=> capt_w[g] == $past(count_w[g]) &&
                ts_w[g] == $past(date_time))
            else $error("freeze-count capture wrong");
    end

    // with the mask steady, irq shows whether a masked status bit is set
    a_irq_level: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $stable(mask_r) |-> irq == |(stat_r & mask_r))
        else $error("irq not following masked status");

    // an event sets its status bit even in a clearing cycle
    a_status_set: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        stat_set != 16'h0000
        |=> (stat_r & $past(stat_set)) == $past(stat_set))
        else $error("event lost from status");

    // every request is answered after exactly one wait cycle
    a_bus_answer: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

endmodule : uec_top

// file: verification/uec_far_logic.sv
// far-side operand source: logic pass strobe, operands and date stamp
// assumes the bench sets wanted operand levels on ops at clock edges
`timescale 1ns/1ps

module uec_far_logic
    import uec_pkg::*;
#(
    parameter int PASS_GAP = 6
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire uec_in_t [UEC_NCH-1:0] ops,
    output uec_in_t [UEC_NCH-1:0] chan_in,
    output logic pass_tick,
    output logic [63:0] date_time
);
    logic [7:0] gap_r;

    // operands move only at a pass edge, so each pass sees settled levels;
    // the date steps once per pass, which keeps stamps predictable
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gap_r <= 8'h00;
            pass_tick <= 1'b0;
            chan_in <= '0;
            date_time <= 64'h0000000000000100;
        end
        else
        begin
            gap_r <= (gap_r == 8'(PASS_GAP - 1)) ? 8'h00 : gap_r + 8'h01;
            pass_tick <= (gap_r == 8'(PASS_GAP - 2));
            if (pass_tick)
            begin
                chan_in <= ops;
                date_time <= date_time + 64'h0000000000000001;
            end
        end
    end
endmodule : uec_far_logic

// file: verification/uec_top_tb.sv
// self-checking bench of the event counter bank
// assumes uec_far_logic feeds operands; registers over avalon-mm
`timescale 1ns/1ps

module uec_top_tb
    import uec_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic power_fail_in = 1'b0;
    logic irq;
    logic pass_tick;
    logic [63:0] date_time;
    logic [UEC_NCH-1:0] above_f, equal_f, below_f;
    uec_in_t [UEC_NCH-1:0] ops = '0;
    uec_in_t [UEC_NCH-1:0] chan_in;
    int fails = 0;
    int tests_run = 0;
    logic [31:0] rv;
    logic [63:0] stamp;

    // free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    uec_far_logic far_u (.sys_clk(sys_clk), .resetn(resetn), .ops(ops),
        .chan_in(chan_in), .pass_tick(pass_tick), .date_time(date_time));

    uec_top dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chan_in(chan_in),
        .pass_tick(pass_tick), .date_time(date_time),
        .power_fail_in(power_fail_in), .above_compare_flag(above_f),
        .equal_compare_flag(equal_f), .below_compare_flag(below_f),
        .irq(irq));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_up();
        fails++;
        $display("MISMATCH at %0t: wait ran out", $time);
        test_done();
    endtask : give_up

    // a pass strobe is seen at the edge that samples it
    task automatic wait_pass();
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pass_tick !== 1'b1 && n < 40);
        if (pass_tick !== 1'b1)
            give_up();
    endtask : wait_pass

    // second pass samples new operands; four more cycles land irq
    task automatic pass();
        wait_pass();
        wait_pass();
        repeat (4) @(posedge sys_clk);
    endtask : pass

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [8:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0)
            give_up();
        rv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(rv, exp);
    endtask : rdc

    function automatic logic [8:0] ch_a(input int ch, input logic [2:0] w);
        return UEC_OFF_CH_BASE + 9'(ch * 32) + {4'h0, w, 2'b00};
    endfunction : ch_a

    // flags packed as above, equal, below
    task automatic flg(input int ch, input logic [2:0] exp);
        check({29'h0, above_f[ch], equal_f[ch], below_f[ch]}, {29'h0, exp});
    endtask : flg

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        rdc(UEC_OFF_ENABLE, 32'h00000000);
        rdc(UEC_OFF_IRQ_STAT, 32'h00000000);
        bus(1'b1, 9'h1FC, 32'hFFFFFFFF);
        rdc(9'h1FC, 32'h00000000);
        check({31'h0, irq}, 32'h00000000);
    endtask : t_reset

    task automatic t_enable();
        bus(1'b1, ch_a(0, UEC_W_PRESET), 32'h7FFFFFFE);
        bus(1'b1, ch_a(1, UEC_W_PRESET), 32'h00000010);
        bus(1'b1, ch_a(2, UEC_W_PRESET), 32'h80000000);
        bus(1'b1, ch_a(1, UEC_W_COMPARE), 32'h00000001);
        ops[0] <= 7'h08;
        bus(1'b1, UEC_OFF_ENABLE, 32'h00000007);
        pass();
        rdc(ch_a(0, UEC_W_COUNT), 32'h7FFFFFFE);
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000000);
        flg(1, 3'b001);
    endtask : t_enable

    // wraps both ways, a falling edge, a preset-select rise and the irq
    task automatic t_wrap();
        ops[0] <= 7'h48;
        ops[2] <= 7'h08;
        pass();
        ops[0] <= 7'h08;
        ops[2] <= 7'h28;
        pass();
        rdc(ch_a(0, UEC_W_COUNT), 32'h7FFFFFFF);
        rdc(ch_a(2, UEC_W_COUNT), 32'h7FFFFFFF);
        ops[0] <= 7'h48;
        ops[2] <= 7'h00;
        pass();
        rdc(ch_a(0, UEC_W_COUNT), 32'h80000000);
        rdc(ch_a(2, UEC_W_COUNT), 32'h7FFFFFFF);
        flg(0, 3'b001);
        flg(2, 3'b100);
        rdc(UEC_OFF_FLAGS, 32'h00030004);
        check({31'h0, irq}, 32'h00000000);
        bus(1'b1, UEC_OFF_IRQ_MASK, 32'h00000100);
        rdc(UEC_OFF_IRQ_STAT, 32'h00000500);
        check({31'h0, irq}, 32'h00000001);
        bus(1'b1, UEC_OFF_IRQ_STAT, 32'h00000100);
        rdc(UEC_OFF_IRQ_STAT, 32'h00000400);
        check({31'h0, irq}, 32'h00000000);
    endtask : t_wrap

    task automatic t_block();
        ops[1] <= 7'h40;
        pass();
        flg(1, 3'b010);
        ops[1] <= 7'h10;
        pass();
        ops[1] <= 7'h50;
        pass();
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000001);
        flg(1, 3'b000);
        ops[1] <= 7'h00;
        pass();
        ops[1] <= 7'h44;
        pass();
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000000);
    endtask : t_block

    task automatic t_freeze();
        ops[1] <= 7'h08;
        pass();
        ops[1] <= 7'h48;
        pass();
        ops[1] <= 7'h0A;
        pass();
        rdc(ch_a(1, UEC_W_CAPT), 32'h00000011);
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000010);
        ops[1] <= 7'h49;
        pass();
        stamp = date_time - 64'h0000000000000001;
        rdc(ch_a(1, UEC_W_CAPT), 32'h00000010);
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000011);
        rdc(ch_a(1, UEC_W_TS_LO), stamp[31:0]);
        rdc(ch_a(1, UEC_W_TS_HI), stamp[63:32]);
    endtask : t_freeze

    // image taken while power fails, then counting moves on and is undone
    task automatic t_power();
        power_fail_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        power_fail_in <= 1'b0;
        ops[1] <= 7'h08;
        pass();
        ops[1] <= 7'h48;
        pass();
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000012);
        bus(1'b1, UEC_OFF_NV_CTRL, 32'h00000001);
        pass();
        rdc(ch_a(1, UEC_W_COUNT), 32'h00000011);
        rdc(ch_a(1, UEC_W_CAPT), 32'h00000010);
    endtask : t_power

    // main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_enable();
        t_wrap();
        t_block();
        t_freeze();
        t_power();
        test_done();
    end
endmodule : uec_top_tb
